//--- rtl/sts_pkg.sv
// shared constants and types of the scan test block
// assumes one system clock samples the serial test port pins
package sts_pkg;
  localparam int IR_W = 8;
  localparam int BSC_W = 48;
  localparam int BCR_W = 3;
  localparam int IDR_W = 32;
  localparam int DATA_HI = 39;
  localparam int SYNC_W = 3;
  localparam int TMS_RESET_RISES = 5;
  localparam int LFSR_TAP = 38;

  localparam logic [7:0] IR_RESET = 8'h81;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] OP_EXTEST = 8'h00;
  localparam logic [7:0] OP_IDCODE = 8'h81;
  localparam logic [7:0] OP_SAMPLE = 8'h82;
  localparam logic [7:0] OP_HIGHZ = 8'h06;
  localparam logic [7:0] OP_CLAMP = 8'h87;
  localparam logic [7:0] OP_BOUNDARY_RUN_TEST = 8'h09;
  localparam logic [7:0] OP_READBN = 8'h0a;
  localparam logic [7:0] OP_READBT = 8'h8b;
  localparam logic [7:0] OP_SCAN_CTRL = 8'h8e;

  localparam logic [2:0] BCR_RESET = 3'h2;
  localparam logic [2:0] RUN_PSEUDO_RANDOM_PATTERN_GEN = 3'h1;
  localparam logic [2:0] RUN_PSA = 3'h2;
  localparam logic [2:0] RUN_COUNT = 3'h5;
  localparam logic [1:0] BSC_OE_RESET = 2'h3;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sts_tap_t;

  typedef enum logic [1:0] {DR_BSC, DR_BCR, DR_BYP, DR_IDR} sts_dr_t;

  typedef struct packed {
    logic test_mode;
    logic highz;
    logic clamp;
    logic boundary_run_test;
    logic cap_pins;
    logic upd_bsc;
    logic upd_bcr;
    sts_dr_t sel;
  } sts_dec_t;

  typedef struct packed {
    logic test_mode;
    logic highz;
    logic clamp;
  } sts_ctl_t;

  // field order is cell 47 down to cell 0
  typedef struct packed {
    logic a_to_b_output_enable;
    logic b_to_a_output_enable;
    logic a_to_b_clock;
    logic b_to_a_clock;
    logic a_to_b_clock_enable;
    logic b_to_a_clock_enable;
    logic a_to_b_latch_enable;
    logic b_to_a_latch_enable;
    logic [19:0] a_port;
    logic [19:0] b_port;
  } sts_bsc_t;
endpackage

//--- rtl/sts_scan_top.sv
// scan test logic: instruction, boundary, boundary-control, bypass and id registers
// assumes tck, tms, tdi come from pins asynchronous to mclk; pin_in is on mclk
// Function
// - update-dr falling edge copies selected shift stage into its shadow latches except under readbn and readbt
// - capture-ir loads 10000001 into instruction shift stage, shifted out later
// - shift-ir places instruction stage on tdo; first fall drives its lsb
// - shift-ir moves one bit per rising edge, none in entry cycle
// - first fall in exit1-ir returns tdo to high impedance
// - exit2 states may return to shift without recapturing the instruction
// - pause-ir holds the partly shifted instruction for any number of cycles
// - update-ir fall copies shift stage into instruction latch, new mode applies
// - shadowed registers except bypass and id, which have shift stage only
// - capture loads stage from instruction-chosen source; shift moves tdi to tdo
// - eight-bit instruction decodes mode, operation, data register and capture source
// - unimplemented opcodes decode as bypass
// - power-up and logic-reset force instruction to 10000001, id read
// - boundary register has 48 cells applying and capturing pin values
// - instruction picks boundary capture source and run-test changes
// - reset sets boundary cells 47 and 46 to one
// - boundary data enters cell 47, leaves from cell 0
// - cells 47..40 port controls, 39..20 a port, 19..0 b port
// - three-bit boundary-control code picks pattern, signature or count under run-test
// - data capture leaves boundary-control contents unchanged
// - reset sets boundary-control to 010, signature analysis
// - controller advances on each rising test clock per tms level
// - tms high reaches logic reset within five test clocks
// - inputs taken on rising edges, tdo changes only on falling edges
// - bypass cell captures zero in data capture
`timescale 1ns/1ps
module sts_scan_top #(
  parameter logic [31:0] IDCODE = 32'h1234_5001 // arbitrary value, bit 0 set
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input sts_pkg::sts_bsc_t pin_in,
  output sts_pkg::sts_bsc_t bsc_out,
  output sts_pkg::sts_ctl_t ctl,
  output sts_pkg::sts_tap_t tap_state
);
  logic [2:0] pins_s;
  logic tck_s, tms_s, tdi_s;
  logic tck_d_q;
  logic rise, fall;
  sts_pkg::sts_tap_t tap;
  sts_pkg::sts_dec_t dec;
  logic dr_lsb;

  logic [7:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [47:0] bsc_sh_q, bsc_sh_d, bsc_up_q, bsc_up_d;
  logic [2:0] bcr_sh_q, bcr_sh_d, bcr_q, bcr_d;
  logic byp_q, byp_d;
  logic [31:0] idr_q, idr_d;
  logic tdo_q, tdo_d, oe_n_q, oe_n_d;

  sts_sync #(.W(sts_pkg::SYNC_W)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din({tck, tms, tdi}),
    .dout(pins_s)
  );
  assign {tck_s, tms_s, tdi_s} = pins_s;

  always_ff @(posedge mclk) begin
    if (srst) begin
      tck_d_q <= 1'b0;
    end else begin
      tck_d_q <= tck_s;
    end
  end
  assign rise = tck_s & ~tck_d_q;
  assign fall = ~tck_s & tck_d_q;

  sts_tap_fsm u_fsm (
    .mclk(mclk),
    .srst(srst),
    .rise(rise),
    .tms(tms_s),
    .state(tap)
  );

  function automatic sts_pkg::sts_dec_t decode(input logic [7:0] op);
    sts_pkg::sts_dec_t r;
    r = '0;
    r.sel = sts_pkg::DR_BYP;
    case (op)
      sts_pkg::OP_EXTEST: begin
        r.test_mode = 1'b1;
        r.sel = sts_pkg::DR_BSC;
        r.cap_pins = 1'b1;
        r.upd_bsc = 1'b1;
      end
      sts_pkg::OP_IDCODE: r.sel = sts_pkg::DR_IDR;
      sts_pkg::OP_SAMPLE: begin
        r.sel = sts_pkg::DR_BSC;
        r.cap_pins = 1'b1;
        r.upd_bsc = 1'b1;
      end
      sts_pkg::OP_HIGHZ: begin
        r.test_mode = 1'b1;
        r.highz = 1'b1;
      end
      sts_pkg::OP_CLAMP: begin
        r.test_mode = 1'b1;
        r.clamp = 1'b1;
      end
      sts_pkg::OP_BOUNDARY_RUN_TEST: begin
        r.test_mode = 1'b1;
        r.boundary_run_test = 1'b1;
      end
      sts_pkg::OP_READBN: r.sel = sts_pkg::DR_BSC;
      sts_pkg::OP_READBT: begin
        r.test_mode = 1'b1;
        r.sel = sts_pkg::DR_BSC;
      end
      sts_pkg::OP_SCAN_CTRL: begin
        r.sel = sts_pkg::DR_BCR;
        r.upd_bcr = 1'b1;
      end
      default: r.sel = sts_pkg::DR_BYP;
    endcase
    return r;
  endfunction

  // run-test operations act on the forty port cells only, so the control cells stay put
  function automatic logic [39:0] run_op(input logic [2:0] code, input logic [39:0] cur,
                                         input logic [39:0] pins);
    logic fb;
    fb = cur[sts_pkg::DATA_HI] ^ cur[sts_pkg::LFSR_TAP];
    case (code)
      sts_pkg::RUN_PSEUDO_RANDOM_PATTERN_GEN: return {cur[38:0], fb};
      sts_pkg::RUN_PSA: return {cur[38:0], fb} ^ pins;
      sts_pkg::RUN_COUNT: return cur + 40'h1;
      default: return cur;
    endcase
  endfunction

  assign dec = decode(ir_q);

  always_comb begin
    case (dec.sel)
      sts_pkg::DR_BSC: dr_lsb = bsc_sh_q[0];
      sts_pkg::DR_BCR: dr_lsb = bcr_sh_q[0];
      sts_pkg::DR_IDR: dr_lsb = idr_q[0];
      default: dr_lsb = byp_q;
    endcase
  end

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    bsc_sh_d = bsc_sh_q;
    bsc_up_d = bsc_up_q;
    bcr_sh_d = bcr_sh_q;
    bcr_d = bcr_q;
    byp_d = byp_q;
    idr_d = idr_q;
    tdo_d = tdo_q;
    oe_n_d = oe_n_q;
    if (rise) begin
      case (tap)
        sts_pkg::ST_CAP_IR: ir_sh_d = sts_pkg::IR_CAPTURE;
        sts_pkg::ST_SH_IR: ir_sh_d = {tdi_s, ir_sh_q[7:1]};
        sts_pkg::ST_CAP_DR: begin
          case (dec.sel)
            sts_pkg::DR_BSC: bsc_sh_d = dec.cap_pins ? 48'(pin_in) : bsc_up_q;
            sts_pkg::DR_BYP: byp_d = 1'b0;
            sts_pkg::DR_IDR: idr_d = IDCODE;
            default: bcr_sh_d = bcr_sh_q;
          endcase
        end
        sts_pkg::ST_SH_DR: begin
          case (dec.sel)
            sts_pkg::DR_BSC: bsc_sh_d = {tdi_s, bsc_sh_q[47:1]};
            sts_pkg::DR_BCR: bcr_sh_d = {tdi_s, bcr_sh_q[2:1]};
            sts_pkg::DR_IDR: idr_d = {tdi_s, idr_q[31:1]};
            default: byp_d = tdi_s;
          endcase
        end
        sts_pkg::ST_IDLE: begin
          if (dec.boundary_run_test) begin
            bsc_up_d[39:0] = run_op(bcr_q, bsc_up_q[39:0], pin_in[39:0]);
          end
        end
        default: ir_sh_d = ir_sh_q;
      endcase
    end
    if (fall) begin
      case (tap)
        sts_pkg::ST_SH_IR: begin
          tdo_d = ir_sh_q[0];
          oe_n_d = 1'b0;
        end
        sts_pkg::ST_SH_DR: begin
          tdo_d = dr_lsb;
          oe_n_d = 1'b0;
        end
        sts_pkg::ST_UPD_IR: begin
          ir_d = ir_sh_q;
          oe_n_d = 1'b1;
        end
        sts_pkg::ST_UPD_DR: begin
          // bypass and id have no shadow stage
          if (dec.upd_bsc) begin
            bsc_up_d = bsc_sh_q;
          end
          if (dec.upd_bcr) begin
            bcr_d = bcr_sh_q;
          end
          oe_n_d = 1'b1;
        end
        default: oe_n_d = 1'b1;
      endcase
    end
    if (tap == sts_pkg::ST_RESET) begin
      ir_d = sts_pkg::IR_RESET;
      bcr_d = sts_pkg::BCR_RESET;
      // shift stage too, so a scan right after logic reset reads 010
      bcr_sh_d = sts_pkg::BCR_RESET;
      bsc_sh_d[47:46] = sts_pkg::BSC_OE_RESET;
      bsc_up_d[47:46] = sts_pkg::BSC_OE_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ir_sh_q <= sts_pkg::IR_RESET;
      ir_q <= sts_pkg::IR_RESET;
      // other cells undefined by nature; cleared for clean simulation
      bsc_sh_q <= {sts_pkg::BSC_OE_RESET, 46'h0};
      bsc_up_q <= {sts_pkg::BSC_OE_RESET, 46'h0};
      bcr_sh_q <= sts_pkg::BCR_RESET;
      bcr_q <= sts_pkg::BCR_RESET;
      byp_q <= 1'b0;
      idr_q <= 32'h0;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      bsc_sh_q <= bsc_sh_d;
      bsc_up_q <= bsc_up_d;
      bcr_sh_q <= bcr_sh_d;
      bcr_q <= bcr_d;
      byp_q <= byp_d;
      idr_q <= idr_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe_n = oe_n_q;
  assign bsc_out = sts_pkg::sts_bsc_t'(bsc_up_q);
  assign ctl = '{test_mode: dec.test_mode, highz: dec.highz, clamp: dec.clamp};
  assign tap_state = tap;

  a_ir_capture: assert property (@(posedge mclk) disable iff (srst)
    (rise && tap == sts_pkg::ST_CAP_IR) |=> (ir_sh_q == 8'h81))
    else $error("capture-ir did not load 10000001");
  a_ir_shift: assert property (@(posedge mclk) disable iff (srst)
    (rise && tap == sts_pkg::ST_SH_IR) |=> (ir_sh_q == {$past(tdi_s), $past(ir_sh_q[7:1])}))
    else $error("instruction stage did not shift one bit");
  a_tdo_drive: assert property (@(posedge mclk) disable iff (srst)
    (fall && tap == sts_pkg::ST_SH_IR) |=> (!tdo_oe_n && tdo == $past(ir_sh_q[0])))
    else $error("tdo not driving instruction lsb");
  a_tdo_float: assert property (@(posedge mclk) disable iff (srst)
    (fall && tap == sts_pkg::ST_EX1_IR) |=> tdo_oe_n)
    else $error("tdo still driven after exit1");
  a_tdo_idle_hiz: assert property (@(posedge mclk) disable iff (srst)
    (tap != sts_pkg::ST_SH_IR && tap != sts_pkg::ST_SH_DR && $past(tap) == tap && $past(fall)) |-> tdo_oe_n)
    else $error("tdo driven outside shift states");
  a_tdo_fall_only: assert property (@(posedge mclk) disable iff (srst)
    !$past(fall) |-> ($stable(tdo) && $stable(tdo_oe_n)))
    else $error("tdo changed without a falling edge");
  a_exit_keep: assert property (@(posedge mclk) disable iff (srst)
    (rise && tap == sts_pkg::ST_EX2_IR && !tms_s) |=> ($stable(ir_sh_q) && tap == sts_pkg::ST_SH_IR))
    else $error("exit2 back to shift disturbed the stage");
  a_pause_hold: assert property (@(posedge mclk) disable iff (srst)
    (tap == sts_pkg::ST_PAU_IR) |=> $stable(ir_sh_q))
    else $error("pause lost instruction bits");
  a_ir_update: assert property (@(posedge mclk) disable iff (srst)
    (fall && tap == sts_pkg::ST_UPD_IR) |=> (ir_q == $past(ir_sh_q)))
    else $error("update-ir did not load instruction");
  a_logic_reset: assert property (@(posedge mclk) disable iff (srst)
    (tap == sts_pkg::ST_RESET) |=> (ir_q == 8'h81 && bcr_q == 3'h2 && bsc_out[47:46] == 2'b11))
    else $error("logic reset values wrong");
  a_bcr_capture: assert property (@(posedge mclk) disable iff (srst)
    (rise && tap == sts_pkg::ST_CAP_DR && dec.sel == sts_pkg::DR_BCR) |=> $stable(bcr_sh_q))
    else $error("boundary-control changed in capture");
  a_bypass_zero: assert property (@(posedge mclk) disable iff (srst)
    (rise && tap == sts_pkg::ST_CAP_DR && dec.sel == sts_pkg::DR_BYP) |=> !byp_q)
    else $error("bypass did not capture zero");
  a_bsc_update: assert property (@(posedge mclk) disable iff (srst)
    (fall && tap == sts_pkg::ST_UPD_DR && dec.upd_bsc) |=> (bsc_up_q == $past(bsc_sh_q)))
    else $error("boundary shadow not updated");

  c_ir_update: cover property (@(posedge mclk) disable iff (srst) fall && tap == sts_pkg::ST_UPD_IR);
  c_bsc_shift: cover property (@(posedge mclk) disable iff (srst)
    rise && tap == sts_pkg::ST_SH_DR && dec.sel == sts_pkg::DR_BSC);
  c_run_test: cover property (@(posedge mclk) disable iff (srst) rise && tap == sts_pkg::ST_IDLE && dec.boundary_run_test);
endmodule // sts_scan_top

//--- rtl/sts_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module sts_sync #(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // sts_sync

//--- rtl/sts_tap_fsm.sv
// sixteen-state test port controller
// assumes rise is a one-cycle pulse per test clock rising edge, tms aligned with it
`timescale 1ns/1ps
module sts_tap_fsm (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rise,
  input wire logic tms,
  output sts_pkg::sts_tap_t state
);
  sts_pkg::sts_tap_t st_q, st_d;
  logic [2:0] hi_cnt_q, hi_cnt_d;

  always_comb begin
    st_d = st_q;
    if (rise) begin
      case (st_q)
        sts_pkg::ST_RESET: st_d = tms ? sts_pkg::ST_RESET : sts_pkg::ST_IDLE;
        sts_pkg::ST_IDLE: st_d = tms ? sts_pkg::ST_SEL_DR : sts_pkg::ST_IDLE;
        sts_pkg::ST_SEL_DR: st_d = tms ? sts_pkg::ST_SEL_IR : sts_pkg::ST_CAP_DR;
        sts_pkg::ST_CAP_DR: st_d = tms ? sts_pkg::ST_EX1_DR : sts_pkg::ST_SH_DR;
        sts_pkg::ST_SH_DR: st_d = tms ? sts_pkg::ST_EX1_DR : sts_pkg::ST_SH_DR;
        sts_pkg::ST_EX1_DR: st_d = tms ? sts_pkg::ST_UPD_DR : sts_pkg::ST_PAU_DR;
        sts_pkg::ST_PAU_DR: st_d = tms ? sts_pkg::ST_EX2_DR : sts_pkg::ST_PAU_DR;
        sts_pkg::ST_EX2_DR: st_d = tms ? sts_pkg::ST_UPD_DR : sts_pkg::ST_SH_DR;
        sts_pkg::ST_UPD_DR: st_d = tms ? sts_pkg::ST_SEL_DR : sts_pkg::ST_IDLE;
        sts_pkg::ST_SEL_IR: st_d = tms ? sts_pkg::ST_RESET : sts_pkg::ST_CAP_IR;
        sts_pkg::ST_CAP_IR: st_d = tms ? sts_pkg::ST_EX1_IR : sts_pkg::ST_SH_IR;
        sts_pkg::ST_SH_IR: st_d = tms ? sts_pkg::ST_EX1_IR : sts_pkg::ST_SH_IR;
        sts_pkg::ST_EX1_IR: st_d = tms ? sts_pkg::ST_UPD_IR : sts_pkg::ST_PAU_IR;
        sts_pkg::ST_PAU_IR: st_d = tms ? sts_pkg::ST_EX2_IR : sts_pkg::ST_PAU_IR;
        sts_pkg::ST_EX2_IR: st_d = tms ? sts_pkg::ST_UPD_IR : sts_pkg::ST_SH_IR;
        sts_pkg::ST_UPD_IR: st_d = tms ? sts_pkg::ST_SEL_DR : sts_pkg::ST_IDLE;
        default: st_d = sts_pkg::ST_RESET;
      endcase
    end
  end

  // helper count of consecutive rises with tms high, read only by checks
  always_comb begin
    hi_cnt_d = hi_cnt_q;
    if (rise) begin
      if (!tms) begin
        hi_cnt_d = 3'h0;
      end else if (hi_cnt_q < 3'(sts_pkg::TMS_RESET_RISES)) begin
        hi_cnt_d = hi_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= sts_pkg::ST_RESET;
      hi_cnt_q <= 3'h0;
    end else begin
      st_q <= st_d;
      hi_cnt_q <= hi_cnt_d;
    end
  end

  assign state = st_q;

  a_tms_reset_bound: assert property (@(posedge mclk) disable iff (srst)
    (hi_cnt_q == 3'(sts_pkg::TMS_RESET_RISES)) |-> (st_q == sts_pkg::ST_RESET))
    else $error("tms held high did not reach logic reset");
endmodule // sts_tap_fsm

//--- tb/scan_test_ir_and_boundary_regs_tb.sv
// self-checking bench for the scan test block
// assumes the controller model makes every tck edge; pin_in set between scans
`timescale 1ns/1ps
module scan_test_ir_and_boundary_regs_tb;
  logic mclk;
  logic srst;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic so;
  logic soe;
  sts_pkg::sts_bsc_t pin_in;
  sts_pkg::sts_bsc_t bsc_out;
  sts_pkg::sts_bsc_t pat;
  sts_pkg::sts_ctl_t ctl;
  sts_pkg::sts_tap_t tap_state;
  int err_count;
  int checks;
  logic [63:0] a;
  logic [63:0] b;
  localparam logic [31:0] ID_VAL = 32'h0000_5a37; // arbitrary value, bit 0 set
  // even-parity opcodes, ctl expectations as {test_mode, highz, clamp}
  localparam logic [7:0] OPS [11] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h06, 8'h87, 8'h88, 8'h09, 8'h0a, 8'h8b};
  localparam logic [2:0] EXP [11] = '{3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h5, 3'h0, 3'h4, 3'h0, 3'h4};
  localparam logic [2:0] MSK [11] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h2, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};

  sts_scan_top #(.IDCODE(ID_VAL)) dut (
    .mclk(mclk),
    .srst(srst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe_n(tdo_oe_n),
    .pin_in(pin_in),
    .bsc_out(bsc_out),
    .ctl(ctl),
    .tap_state(tap_state)
  );

  sts_ctrl_model m_ctrl (
    .mclk(mclk),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe_n(tdo_oe_n)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic st(input logic m);
    m_ctrl.step(m, 1'b1, so, soe);
  endtask

  // lsb first; the last bit leaves the shift state
  task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      m_ctrl.step(i == n - 1, din[i], so, soe);
      dout[i] = so;
      chk(64'(soe), 64'h0);
    end
  endtask

  // full scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    st(1'b1);
    if (ir) begin
      st(1'b1);
    end
    st(1'b0);
    st(1'b0);
    shift(n, din, dout);
    st(1'b1);
    chk(64'(soe), 64'h1);
    st(1'b0);
    chk(64'(soe), 64'h1);
  endtask

  task automatic close_out;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // about 11k mclk expected; a stalled handshake ends here
  initial begin
    #300000;
    err_count++;
    close_out();
  end

  initial begin
    srst = 1'b1;
    pin_in = '0;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(64'(tap_state), 64'(sts_pkg::ST_RESET));
    chk(64'(ctl), 64'h0);
    chk(64'(bsc_out[47:46]), 64'h3);
    chk(64'(tdo_oe_n), 64'h1);
    st(1'b0);
    scan(1'b0, 32, 64'h0, a);
    chk(a, 64'(ID_VAL));
    for (int i = 0; i < 11; i++) begin
      scan(1'b1, 8, 64'(OPS[i]), a);
      chk(a, 64'h81);
      chk(64'(ctl & MSK[i]), 64'(EXP[i]));
    end
    // unimplemented code; bypass cell leads the delayed tdi bits
    scan(1'b1, 8, 64'h84, a);
    scan(1'b0, 4, 64'h6, a);
    chk(a, 64'hc);
    pin_in = 48'h9a5c_3e71_0f2d;
    pat = 48'h35a7_c1e8_f0d2;
    scan(1'b1, 8, 64'h82, a);
    scan(1'b0, 48, 64'(pat), a);
    chk(a, 64'(pin_in));
    chk(64'(bsc_out), 64'(pat));
    chk(64'(bsc_out.a_port), 64'(pat[39:20]));
    scan(1'b1, 8, 64'h0a, a);
    scan(1'b0, 48, 64'h0, a);
    chk(a, 64'(pat));
    // instruction scan split by a pause, resumed through exit2
    st(1'b1);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    shift(4, 64'h0, a);
    repeat (4) st(1'b0);
    chk(64'(tap_state), 64'(sts_pkg::ST_PAU_IR));
    st(1'b1);
    st(1'b0);
    shift(4, 64'h0, b);
    st(1'b1);
    st(1'b0);
    chk({56'h0, b[3:0], a[3:0]}, 64'h81);
    chk(64'(ctl), 64'h4);
    scan(1'b1, 8, 64'h8e, a);
    scan(1'b0, 3, 64'h5, a);
    chk(a, 64'h2);
    scan(1'b0, 3, 64'h5, a);
    chk(a, 64'h5);
    // up-count code now active; each idle rise under run-test adds one to port cells
    scan(1'b1, 8, 64'h09, a);
    repeat (3) st(1'b0);
    chk(64'(bsc_out[39:0]), 64'(pat[39:0]) + 64'h3);
    // farthest state from logic reset, then tms held high
    st(1'b1);
    st(1'b0);
    st(1'b0);
    st(1'b1);
    st(1'b0);
    chk(64'(tap_state), 64'(sts_pkg::ST_PAU_DR));
    repeat (5) st(1'b1);
    chk(64'(tap_state), 64'(sts_pkg::ST_RESET));
    chk(64'(bsc_out[47:46]), 64'h3);
    st(1'b0);
    chk(64'(ctl), 64'h0);
    scan(1'b1, 8, 64'h8e, a);
    scan(1'b0, 3, 64'h0, a);
    chk(a, 64'h2);
    close_out();
  end
endmodule // scan_test_ir_and_boundary_regs_tb

//--- tb/sts_ctrl_model.sv
// external scan controller model driving the four-wire test port
// assumes mclk is the bench clock; one tck period is 25 mclk, 125 ns
`timescale 1ns/1ps
module sts_ctrl_model (
  input wire logic mclk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  logic last_q;

  // pins idle high like their pull-ups; tck stands low between steps
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_q = 1'b0;
  end

  always @(posedge mclk) begin
    if (!tdo_oe_n) begin
      last_q <= tdo;
    end
  end

  // one tck period; levels held across the rising edge, tdo read just before it
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    @(posedge mclk);
    #1;
    tms = m;
    tdi = d;
    repeat (12) @(posedge mclk);
    #1;
    // a released line never shows the stale driven level
    o = tdo_oe_n ? ~last_q : tdo;
    oe = tdo_oe_n;
    tck = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    tck = 1'b0;
  endtask
endmodule // sts_ctrl_model
